/* File: rtl/rdcb_top.sv */
// Dropped-frame tally, indirect MAC register access and high-level flow control
`timescale 1ns/100ps
`default_nettype none
module rdcb_top #(
  parameter int FILL_W = 14,
  parameter int unsigned JAM_DIV = 1
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rx_drop_i,
  output rdcb_pkg::rdcb_mac_req_t mac_req_o,
  input wire logic mac_ack_i,
  input wire logic [31:0] mac_rdata_i,
  input wire logic tx_enable_i,
  input wire logic full_duplex_i,
  input wire logic speed_100_i,
  input wire logic [FILL_W-1:0] rx_fill_bytes_i,
  input wire rdcb_pkg::rdcb_frame_t frame_i,
  input wire logic [15:0] pause_time_value_i,
  output logic pause_req_o,
  output logic [15:0] pause_time_o,
  output logic jam_o,
  output logic irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Write channel capture, address and data taken in either order
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic ar_held;
  logic [7:0] ar_addr;

  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  wire [7:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
  wire [3:0] wr_strb = w_held ? w_strb : s_axi_wstrb;
  wire wr_fire = (aw_held || aw_take) && (w_held || w_take);

  wire [31:0] byte_mask;
  genvar gb;
  generate
    for (gb = 0; gb < 4; gb++) begin : g_lane
      assign byte_mask[8*gb +: 8] = {8{wr_strb[gb]}};
    end
  endgenerate

  wire wr_drop = wr_fire && (wr_addr == rdcb_pkg::ADDR_DROP);
  wire wr_cmd = wr_fire && (wr_addr == rdcb_pkg::ADDR_CMD);
  wire wr_data_reg = wr_fire && (wr_addr == rdcb_pkg::ADDR_DATA);
  wire wr_afc = wr_fire && (wr_addr == rdcb_pkg::ADDR_AFC);
  wire wr_stat = wr_fire && (wr_addr == rdcb_pkg::ADDR_IRQ_STAT);
  wire wr_en = wr_fire && (wr_addr == rdcb_pkg::ADDR_IRQ_EN);
  wire wr_clr = wr_fire && (wr_addr == rdcb_pkg::ADDR_IRQ_CLR);
  wire wr_hit = wr_drop || wr_cmd || wr_data_reg || wr_afc || wr_stat || wr_en || wr_clr;

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= rdcb_pkg::RESP_OKAY;
    end else begin
      if (aw_take && !wr_fire) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (w_take && !wr_fire) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? rdcb_pkg::RESP_OKAY : rdcb_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel, one cycle from address to data
  assign s_axi_arready = !s_axi_rvalid;
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire rd_drop = ar_take && (s_axi_araddr == rdcb_pkg::ADDR_DROP);

  logic [31:0] drop_count;
  logic busy;
  logic dir_rd;
  logic [7:0] csr_addr;
  logic [31:0] csr_data;
  logic [31:0] auto_pause_config;
  logic [rdcb_pkg::IRQ_W-1:0] irq_stat;
  logic [rdcb_pkg::IRQ_W-1:0] irq_en;

  wire [31:0] cmd_view = {busy, dir_rd, 22'h000000, csr_addr};
  logic [31:0] rd_mux;
  logic rd_ok;
  always_comb begin
    rd_ok = 1'b1;
    case (s_axi_araddr)
      rdcb_pkg::ADDR_DROP: rd_mux = drop_count;
      rdcb_pkg::ADDR_CMD: rd_mux = cmd_view;
      rdcb_pkg::ADDR_DATA: rd_mux = csr_data;
      rdcb_pkg::ADDR_AFC: rd_mux = auto_pause_config;
      rdcb_pkg::ADDR_IRQ_STAT: rd_mux = {30'h00000000, irq_stat};
      rdcb_pkg::ADDR_IRQ_EN: rd_mux = {30'h00000000, irq_en};
      default: begin
        rd_mux = 32'h00000000;
        rd_ok = rdcb_pkg::ADDR_IRQ_CLR == s_axi_araddr;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= rdcb_pkg::RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_ok ? rdcb_pkg::RESP_OKAY : rdcb_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Dropped-frame tally; a drop in the read cycle survives the clear
  wire half_cross = rx_drop_i && (drop_count == rdcb_pkg::HALF_POINT);
  wire [31:0] next_drop_count = rd_drop ? {31'h00000000, rx_drop_i}
                                        : drop_count + {31'h00000000, rx_drop_i};

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      drop_count <= rdcb_pkg::DROP_RESET;
    end else begin
      drop_count <= next_drop_count;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Indirect MAC register access
  rdcb_pkg::rdcb_csr_state_t csr_state;
  wire start_cmd = wr_cmd && !busy && wr_strb[3] && wr_data[rdcb_pkg::CMD_BUSY_BIT];
  wire csr_done = (csr_state == rdcb_pkg::CSR_WAIT) && mac_ack_i;
  wire [31:0] cmd_merge = ((cmd_view & ~byte_mask) | (wr_data & byte_mask)) & rdcb_pkg::CMD_WR_MASK;

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      csr_state <= rdcb_pkg::CSR_IDLE;
      busy <= 1'b0;
      dir_rd <= 1'b0;
      csr_addr <= 8'h00;
      csr_data <= rdcb_pkg::DATA_RESET;
    end else begin
      case (csr_state)
        rdcb_pkg::CSR_IDLE: begin
          // Busy writes are dropped so a running access stays coherent
          if (wr_cmd) begin
            dir_rd <= cmd_merge[rdcb_pkg::CMD_DIR_BIT];
            csr_addr <= cmd_merge[7:0];
          end
          if (wr_data_reg) begin
            csr_data <= (csr_data & ~byte_mask) | (wr_data & byte_mask);
          end
          if (start_cmd) begin
            busy <= 1'b1;
            csr_state <= rdcb_pkg::CSR_WAIT;
          end
        end
        rdcb_pkg::CSR_WAIT: begin
          if (mac_ack_i) begin
            busy <= 1'b0;
            if (dir_rd) begin
              csr_data <= mac_rdata_i;
            end
            csr_state <= rdcb_pkg::CSR_IDLE;
          end
        end
        default: csr_state <= rdcb_pkg::CSR_IDLE;
      endcase
    end
  end

  assign mac_req_o.valid = csr_state == rdcb_pkg::CSR_WAIT;
  assign mac_req_o.rd = dir_rd;
  assign mac_req_o.addr = csr_addr;
  assign mac_req_o.wdata = csr_data;

  ////////////////////////////////////////////////////////////////////////////
  // Flow control configuration and automatic pause or jam
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      auto_pause_config <= rdcb_pkg::AFC_RESET;
    end else if (wr_afc) begin
      auto_pause_config <= ((auto_pause_config & ~byte_mask) | (wr_data & byte_mask)) & rdcb_pkg::AFC_WR_MASK;
    end
  end

  wire [7:0] hi_level = auto_pause_config[rdcb_pkg::PAUSE_HIGH_THRESHOLD_LSB +: 8];
  wire [3:0] jam_sel = auto_pause_config[rdcb_pkg::AFC_DUR_LSB +: 4];
  wire fc_any = auto_pause_config[rdcb_pkg::AFC_ANY_BIT];
  wire [8+rdcb_pkg::FILL_UNIT_SHIFT-1:0] hi_bytes = {hi_level, 6'h00};
  wire above_hi = 32'(rx_fill_bytes_i) >= 32'(hi_bytes);
  wire frame_match = fc_any || (auto_pause_config[rdcb_pkg::AFC_MCAST_BIT] && frame_i.mcast)
                     || (auto_pause_config[rdcb_pkg::AFC_BCAST_BIT] && frame_i.bcast)
                     || (auto_pause_config[rdcb_pkg::AFC_ADDR_BIT] && frame_i.addr_hit);

  // Jam length in cycles; JAM_DIV only shortens it for simulation
  function automatic logic [15:0] jam_cycles(input logic [3:0] sel, input logic fast);
    int unsigned ns;
    ns = rdcb_pkg::JAM_100_NS[sel] + (fast ? 0 : rdcb_pkg::JAM_10_EXTRA_NS);
    return 16'(ns / rdcb_pkg::CLK_PERIOD_NS / JAM_DIV);
  endfunction : jam_cycles

  logic above_q;
  logic [15:0] jam_left;
  wire pause_fire = full_duplex_i && tx_enable_i && fc_any && above_hi && !above_q;
  wire jam_start = !full_duplex_i && tx_enable_i && frame_i.start && above_hi && frame_match;

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      above_q <= 1'b0;
      jam_left <= 16'h0000;
      pause_req_o <= 1'b0;
      pause_time_o <= 16'h0000;
    end else begin
      above_q <= above_hi;
      pause_req_o <= pause_fire;
      if (pause_fire) begin
        pause_time_o <= pause_time_value_i;
      end
      if (!tx_enable_i || full_duplex_i) begin
        jam_left <= 16'h0000;
      end else if (jam_start) begin
        jam_left <= jam_cycles(jam_sel, speed_100_i);
      end else if (jam_left != 16'h0000) begin
        jam_left <= jam_left - 16'h0001;
      end
    end
  end

  assign jam_o = jam_left != 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts; a new event outranks a clear in the same cycle
  wire [rdcb_pkg::IRQ_W-1:0] irq_set = {csr_done, half_cross};
  wire [rdcb_pkg::IRQ_W-1:0] irq_clr = wr_clr && wr_strb[0] ? wr_data[rdcb_pkg::IRQ_W-1:0] : 2'h0;

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_stat <= 2'h0;
      irq_en <= 2'h0;
    end else begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_set;
      if (wr_en && wr_strb[0]) begin
        irq_en <= wr_data[rdcb_pkg::IRQ_W-1:0];
      end
    end
  end

  assign irq_o = |(irq_stat & irq_en);

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  drop_count_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    !rd_drop && rx_drop_i |=> drop_count == $past(drop_count) + 32'h00000001)
    else $error("drop tally did not step");

  read_clear_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    rd_drop |=> s_axi_rdata == $past(drop_count) && drop_count == {31'h00000000, $past(rx_drop_i)})
    else $error("tally read did not clear");

  half_event_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    rx_drop_i && !rd_drop && drop_count == rdcb_pkg::HALF_POINT
    |=> drop_count == rdcb_pkg::HALF_POINT + 32'h00000001 && irq_stat[rdcb_pkg::IRQ_HALF_BIT])
    else $error("halfway event missing");

  start_busy_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    start_cmd |=> busy && mac_req_o.valid)
    else $error("indirect access not started");

  busy_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    busy && !mac_ack_i |=> busy)
    else $error("busy dropped early");

  read_data_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    busy && mac_ack_i && dir_rd |=> !busy && csr_data == $past(mac_rdata_i))
    else $error("read result not captured");

  dir_stable_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    mac_req_o.valid && $past(mac_req_o.valid) |-> $stable(mac_req_o.rd) && $stable(mac_req_o.addr))
    else $error("request changed while busy");

  tx_off_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    !tx_enable_i |=> !jam_o && !pause_req_o)
    else $error("flow control with transmitter off");

  one_pause_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    pause_req_o |=> !pause_req_o)
    else $error("more than one pause frame");

  jam_len_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    jam_start |=> jam_o && jam_left == jam_cycles($past(jam_sel), $past(speed_100_i)))
    else $error("jam length wrong");

  jam_fdx_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    full_duplex_i |=> !jam_o)
    else $error("jam in full duplex");

  busy_clear_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    busy && mac_ack_i |=> !busy && !mac_req_o.valid)
    else $error("busy not cleared on ack");

  busy_data_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    busy && !mac_ack_i |=> csr_data == $past(csr_data))
    else $error("data changed while busy");

  done_event_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    csr_done |=> irq_stat[rdcb_pkg::IRQ_DONE_BIT])
    else $error("done event missing");

  pause_time_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    pause_fire |=> pause_req_o && pause_time_o == $past(pause_time_value_i))
    else $error("pause time not loaded");

  pause_gate_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    !full_duplex_i || !fc_any |=> !pause_req_o)
    else $error("pause outside full duplex");

  afc_reserved_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    auto_pause_config[31:24] == 8'h00)
    else $error("reserved config bits set");

  jam_step_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    jam_o && !jam_start && tx_enable_i && !full_duplex_i |=> jam_left == $past(jam_left) - 16'h0001)
    else $error("jam count did not step");

  jam_idle_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    !jam_o && !jam_start |=> !jam_o)
    else $error("jam without trigger");

  any_frame_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    fc_any && frame_i.start && above_hi && tx_enable_i && !full_duplex_i |=> jam_o)
    else $error("every-frame select ignored");

endmodule : rdcb_top
`default_nettype wire

/* File: rtl/rdcb_pkg.sv */
// Constants, register map and carrier types of the dropped-frame, indirect CSR and pause block
// Notes on behaviour
// - Count every discarded receive frame in a 32-bit tally.
// - Reading the tally returns it, then zeroes it.
// - Raise an event when the tally steps from 7FFFFFFF to 80000000.
// - Writing busy bit 31 as one starts the indirect MAC access.
// - Busy stays set during the access; clear means read data is valid.
// - Bit 30 one means read, zero means write.
// - Bits 7 to 0 pick the internal MAC register.
// - Data register feeds writes and receives read results.
// - No pause frame and no jamming while the transmitter is off.
// - High threshold in bits 23:16, units of 64 bytes, reset zero.
// - Reaching the threshold jams or pauses as bits 3 to 0 select; here pause needs bit 0 alone, bits 3 to 1 only select jamming.
// - Full duplex: one pause frame carrying the MAC pause time.
// - Half duplex: jam each matching frame for the set duration.
// - Jam length from bits 7:4; unused in full duplex.
// - Every-frame bit 0 overrides the other select bits.
package rdcb_pkg;

  localparam logic [7:0] ADDR_DROP = 8'hA0;
  localparam logic [7:0] ADDR_CMD = 8'hA4;
  localparam logic [7:0] ADDR_DATA = 8'hA8;
  localparam logic [7:0] ADDR_AFC = 8'hAC;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'hC0;
  localparam logic [7:0] ADDR_IRQ_EN = 8'hC4;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'hC8;

  localparam int CMD_BUSY_BIT = 31;
  localparam int CMD_DIR_BIT = 30;
  localparam logic [31:0] CMD_WR_MASK = 32'hC00000FF;
  localparam logic [31:0] AFC_WR_MASK = 32'h00FFFFFF;
  localparam int PAUSE_HIGH_THRESHOLD_LSB = 16;
  localparam int AFC_DUR_LSB = 4;
  localparam int AFC_ANY_BIT = 0;
  localparam int AFC_ADDR_BIT = 1;
  localparam int AFC_BCAST_BIT = 2;
  localparam int AFC_MCAST_BIT = 3;
  localparam int FILL_UNIT_SHIFT = 6;

  localparam logic [31:0] DROP_RESET = 32'h00000000;
  localparam logic [31:0] DATA_RESET = 32'h00000000;
  localparam logic [31:0] AFC_RESET = 32'h00000000;
  localparam logic [31:0] HALF_POINT = 32'h7FFFFFFF;

  localparam int IRQ_W = 2;
  localparam int IRQ_HALF_BIT = 0;
  localparam int IRQ_DONE_BIT = 1;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned JAM_100_NS [16] = '{5000, 10000, 15000, 25000, 50000, 100000, 150000, 200000,
                                              250000, 300000, 350000, 400000, 450000, 500000, 550000, 600000};
  localparam int unsigned JAM_10_EXTRA_NS = 2200;

  typedef struct packed {
    logic valid;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } rdcb_mac_req_t;

  typedef struct packed {
    logic start;
    logic mcast;
    logic bcast;
    logic addr_hit;
  } rdcb_frame_t;

  typedef enum logic {CSR_IDLE, CSR_WAIT} rdcb_csr_state_t;

endpackage : rdcb_pkg

/* File: tb/rdcb_mac_model.sv */
// Behavioural internal MAC register file answering indirect accesses
`timescale 1ns/100ps
`default_nettype none
module rdcb_mac_model (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire rdcb_pkg::rdcb_mac_req_t mac_req_i,
  input wire logic [3:0] delay_i,
  output logic mac_ack_o,
  output logic [31:0] mac_rdata_o
);
  logic [31:0] mem [256];
  logic [3:0] wait_cnt;
  logic served;
  // One ack per request; idle data toggles so stale data never looks valid
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mac_ack_o <= 1'h0;
      wait_cnt <= 4'h0;
      served <= 1'h0;
      mac_rdata_o <= 32'h00000000;
    end else begin
      mac_ack_o <= 1'h0;
      mac_rdata_o <= ~mac_rdata_o;
      if (!mac_req_i.valid) begin
        served <= 1'h0;
        wait_cnt <= 4'h0;
      end else if (!served && wait_cnt == delay_i) begin
        mac_ack_o <= 1'h1;
        served <= 1'h1;
        if (mac_req_i.rd) begin
          mac_rdata_o <= mem[mac_req_i.addr];
        end else begin
          mem[mac_req_i.addr] <= mac_req_i.wdata;
        end
      end else if (!served) begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end
  end
endmodule : rdcb_mac_model
`default_nettype wire

/* File: tb/rdcb_top_tb.sv */
// Self-checking bench for the dropped-frame, indirect access and pause block
`timescale 1ns/100ps
`default_nettype none
module rdcb_top_tb;
  localparam int unsigned JAM_DIV = 4;
  logic clk = 1'h0;
  logic rstn = 1'h0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic bready = 1'h0;
  logic arvalid = 1'h0;
  logic rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, mac_ack, pause_req, jam, irq;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rdat, mac_rdata;
  logic [15:0] pause_time, ptime;
  rdcb_pkg::rdcb_mac_req_t mac_req;
  rdcb_pkg::rdcb_frame_t frame_in = 4'h0;
  logic rx_drop = 1'h0;
  logic tx_en = 1'h0;
  logic fdx = 1'h0;
  logic [13:0] fill = 14'h0000;
  logic [15:0] pause_val = 16'h0000;
  logic [3:0] mac_delay = 4'h1;
  logic spd = 1'h1;
  int fails = 0;
  int n_compared = 0;
  int n_pause = 0;
  int n_jam = 0;

  always #12.5 clk = ~clk;

  rdcb_top #(.JAM_DIV(JAM_DIV)) u_dut (.ref_clk_i(clk), .rstn_i(rstn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rx_drop_i(rx_drop), .mac_req_o(mac_req), .mac_ack_i(mac_ack), .mac_rdata_i(mac_rdata),
    .tx_enable_i(tx_en), .full_duplex_i(fdx), .speed_100_i(spd), .rx_fill_bytes_i(fill),
    .frame_i(frame_in), .pause_time_value_i(pause_val), .pause_req_o(pause_req),
    .pause_time_o(pause_time), .jam_o(jam), .irq_o(irq));

  rdcb_mac_model u_mac (.ref_clk_i(clk), .rstn_i(rstn), .mac_req_i(mac_req), .delay_i(mac_delay),
    .mac_ack_o(mac_ack), .mac_rdata_o(mac_rdata));

  // Outputs read before this edge's updates land, so no race with the design
  always @(posedge clk) begin
    if (pause_req === 1'h1) begin
      n_pause++;
      ptime = pause_time;
    end
    if (jam === 1'h1) begin
      n_jam++;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("compared %0d mismatched %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic hang(input string what);
    fails++;
    $display("wrong value %s expected answer seen timeout", what);
    wrap_up();
  endtask : hang

  // Ready sampled at the falling edge; the transfer happens at the next rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic ta, tw, tb;
    n = 0;
    tb = 1'h0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!tb) begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid && bready;
      resp = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
      if (tb) bready <= 1'h0;
      n++;
      if (n > 100) hang("write response");
    end
  endtask : wr

  task automatic rd(input logic [7:0] a);
    int n;
    logic ta, tr;
    n = 0;
    tr = 1'h0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    while (!tr) begin
      @(negedge clk);
      ta = arvalid && arready;
      tr = rvalid && rready;
      resp = rresp;
      rdat = rdata;
      @(posedge clk);
      if (ta) arvalid <= 1'h0;
      if (tr) rready <= 1'h0;
      n++;
      if (n > 100) hang("read response");
    end
  endtask : rd

  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(what, exp, rdat);
  endtask : rdc

  // Host reads the command register until busy bit 31 clears
  task automatic poll_idle;
    int n;
    n = 0;
    rd(rdcb_pkg::ADDR_CMD);
    while (rdat[31] !== 1'h0) begin
      rd(rdcb_pkg::ADDR_CMD);
      n++;
      if (n > 50) hang("busy clear");
    end
  endtask : poll_idle

  task automatic frame(input logic [3:0] f, input int exp, input string what);
    @(negedge clk);
    n_jam = 0;
    @(posedge clk);
    frame_in <= f;
    @(posedge clk);
    frame_in <= 4'h0;
    repeat (120) @(posedge clk);
    chk(what, 32'(exp), 32'(n_jam));
  endtask : frame

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'h1;
    rdc("tally reset", rdcb_pkg::ADDR_DROP, 32'h00000000);
    rdc("cmd reset", rdcb_pkg::ADDR_CMD, 32'h00000000);
    rdc("data reset", rdcb_pkg::ADDR_DATA, 32'h00000000);
    rdc("afc reset", rdcb_pkg::ADDR_AFC, 32'h00000000);
    rdc("unmapped data", 8'h50, 32'h00000000);
    chk("unmapped rresp", 32'h2, 32'(resp));
    wr(8'h50, 32'hFFFFFFFF);
    chk("unmapped bresp", 32'h2, 32'(resp));
    wr(rdcb_pkg::ADDR_AFC, 32'hFFFFFFFF);
    rdc("afc reserved", rdcb_pkg::ADDR_AFC, 32'h00FFFFFF);
    wr(rdcb_pkg::ADDR_CMD, 32'h7FFFFF34);
    rdc("cmd reserved", rdcb_pkg::ADDR_CMD, 32'h40000034);
    $display("test registers done");
    @(posedge clk);
    rx_drop <= 1'h1;
    repeat (3) @(posedge clk);
    rx_drop <= 1'h0;
    rdc("tally", rdcb_pkg::ADDR_DROP, 32'h00000003);
    rdc("tally cleared", rdcb_pkg::ADDR_DROP, 32'h00000000);
    $display("test tally done");
    wr(rdcb_pkg::ADDR_DATA, 32'hA5A55A5A);
    wr(rdcb_pkg::ADDR_CMD, 32'h80000012);
    poll_idle();
    chk("mac write", 32'hA5A55A5A, u_mac.mem[8'h12]);
    wr(rdcb_pkg::ADDR_DATA, 32'h00000000);
    mac_delay <= 4'h9;
    wr(rdcb_pkg::ADDR_CMD, 32'hC0000012);
    wr(rdcb_pkg::ADDR_DATA, 32'h0000DEAD);
    @(negedge clk);
    chk("busy held", 32'h1, 32'(mac_req.valid));
    poll_idle();
    chk("cmd done", 32'h40000012, rdat);
    rdc("mac read", rdcb_pkg::ADDR_DATA, 32'hA5A55A5A);
    $display("test indirect done");
    rdc("irq status", rdcb_pkg::ADDR_IRQ_STAT, 32'h00000002);
    chk("irq masked", 32'h0, 32'(irq));
    wr(rdcb_pkg::ADDR_IRQ_EN, 32'h00000002);
    @(negedge clk);
    chk("irq raised", 32'h1, 32'(irq));
    wr(rdcb_pkg::ADDR_IRQ_CLR, 32'h00000002);
    @(negedge clk);
    chk("irq cleared", 32'h0, 32'(irq));
    $display("test interrupt done");
    @(posedge clk);
    pause_val <= 16'h1234;
    fdx <= 1'h1;
    tx_en <= 1'h1;
    fill <= 14'h0064;
    wr(rdcb_pkg::ADDR_AFC, 32'h00020001);
    repeat (4) @(posedge clk);
    chk("no pause below", 32'h0, 32'(n_pause));
    fill <= 14'h0080;
    repeat (8) @(posedge clk);
    chk("pause count", 32'h1, 32'(n_pause));
    chk("pause time", 32'h1234, 32'(ptime));
    fill <= 14'h0000;
    tx_en <= 1'h0;
    repeat (2) @(posedge clk);
    fill <= 14'h00C8;
    repeat (8) @(posedge clk);
    chk("pause tx off", 32'h1, 32'(n_pause));
    $display("test pause done");
    fdx <= 1'h0;
    tx_en <= 1'h1;
    wr(rdcb_pkg::ADDR_AFC, 32'h00020012);
    frame(4'hA, 0, "jam unmatched");
    frame(4'h9, rdcb_pkg::JAM_100_NS[1] / rdcb_pkg::CLK_PERIOD_NS / JAM_DIV, "jam dur1");
    wr(rdcb_pkg::ADDR_AFC, 32'h00020001);
    frame(4'h8, rdcb_pkg::JAM_100_NS[0] / rdcb_pkg::CLK_PERIOD_NS / JAM_DIV, "jam any");
    spd <= 1'h0;
    frame(4'h8, (rdcb_pkg::JAM_100_NS[0] + rdcb_pkg::JAM_10_EXTRA_NS) / rdcb_pkg::CLK_PERIOD_NS / JAM_DIV,
      "jam 10M");
    spd <= 1'h1;
    tx_en <= 1'h0;
    frame(4'h8, 0, "jam tx off");
    tx_en <= 1'h1;
    fill <= 14'h0040;
    frame(4'h8, 0, "jam below");
    $display("test jam done");
    wrap_up();
  end
endmodule : rdcb_top_tb
`default_nettype wire
